// ==== rtl/cmpf_consts.svh ====
`ifndef CMPF_CONSTS_SVH
`define CMPF_CONSTS_SVH
// Register offsets (byte addresses on the plain port)
`define CMPF_OFS_CFG0 8'h00
`define CMPF_OFS_CFG1 8'h04
`define CMPF_OFS_STAT 8'h08
`define CMPF_OFS_MASK 8'h0c
`define CMPF_OFS_PWR 8'h10
// Configuration register fields
`define CMPF_BIT_EN 0
`define CMPF_BIT_OUTEN 1
`define CMPF_BIT_PSEL 2
`define CMPF_BIT_NSEL 3
`define CMPF_BIT_IEN 4
`define CMPF_BIT_FLAG 5
`define CMPF_BIT_RES 6
// Aux power control: comparator shutdown bit
`define CMPF_BIT_PWROFF 5
// Power mode register fields
`define CMPF_BIT_IDLE 0
`define CMPF_BIT_PD 1
`define CMPF_BIT_TPD 2
// Reset values
`define CMPF_RST_CFG 8'h00
`define CMPF_RST_MASK 8'h00
`define CMPF_RST_PWR 8'h00
// Settling time after enable, ns, and derived cycles at 20 MHz
`define CMPF_SETTLE_NS 10000
`define CMPF_CLK_NS 50
`define CMPF_SETTLE_CYC ((`CMPF_SETTLE_NS + `CMPF_CLK_NS - 1) / `CMPF_CLK_NS)
`endif

// ==== rtl/cmpf_pkg.sv ====
package cmpf_pkg;
    typedef logic [7:0] cmpf_addr_t;
    typedef logic [7:0] cmpf_data_t;
    typedef enum logic [1:0] {
        CMPF_RUN = 2'b00,
        CMPF_IDLE = 2'b01,
        CMPF_PD = 2'b10,
        CMPF_TPD = 2'b11
    } cmpf_pmode_t;
endpackage : cmpf_pkg

// ==== rtl/cmpf_sync.sv ====
`timescale 1ns/1ns
module cmpf_sync (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Async level in, synchronised level out
    input wire logic i_async,
    output logic o_sync
);
    logic meta_r;
    logic sync_r;

    // Resets high to match the forced-high idle comparator level
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : cmpf_sync

// ==== rtl/cmpf_chan.sv ====
`timescale 1ns/1ns
`include "cmpf_consts.svh"
module cmpf_chan (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Control
    input wire logic i_active,
    input wire logic i_clr,
    // Raw analog result
    input wire logic i_raw,
    // Status
    output logic o_result,
    output logic o_flag,
    output logic o_change
);
    logic sync_s;
    logic prev_r;
    logic flag_r;
    logic change_s;

    cmpf_sync u_sync (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_async(i_raw),
        .o_sync(sync_s)
    );

    // Forced high while off, so switching off from low makes an edge
    logic eff_s;
    assign eff_s = i_active ? sync_s : 1'b1;

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= eff_s;
        end
    end

    assign change_s = eff_s != prev_r;

    // Set beats a clearing write in the same cycle
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            flag_r <= 1'b0;
        end else if (change_s) begin
            flag_r <= 1'b1;
        end else if (i_clr) begin
            flag_r <= 1'b0;
        end
    end

    assign o_result = prev_r;
    assign o_flag = flag_r;
    assign o_change = change_s;

    a_flag_sets: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) change_s |=> flag_r)
        else $error("flag not set after change");
    a_set_wins: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) (change_s && i_clr) |=> flag_r)
        else $error("clear beat a change");
    a_off_high: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) !i_active [*2] |=> o_result)
        else $error("disabled result not high");
    a_flag_holds: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) (flag_r && !i_clr) |=> flag_r)
        else $error("flag dropped without clear");
endmodule : cmpf_chan

// ==== rtl/cmpf_top.sv ====
// What this block does
// - Each result reads one when plus input exceeds minus, is readable and may drive a pin.
// - Plus input is one of two pins, minus input is a pin or the internal reference.
// - Each comparator has a change flag in its config register set on any output change.
// - Flags can be polled and raise an interrupt when that interrupt is enabled and its status mask bit is set.
// - Both comparators share one interrupt line and software reads both flags.
// - A disabled comparator's output is forced high.
// - Forcing a low output high on disable sets the flag and may interrupt.
// - Comparators keep running in idle and power-down and stop in total power-down.
// - In idle or power-down an enabled change wakes the core, and raises the interrupt if its status mask bit is set.
// - Bit 5 of the aux power control register disables both comparators.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
`include "cmpf_consts.svh"
module cmpf_top
    import cmpf_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Register port
    input wire cmpf_pkg::cmpf_addr_t i_addr,
    input wire cmpf_pkg::cmpf_data_t i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output cmpf_pkg::cmpf_data_t o_rdata,
    // Power mode from the core
    input wire cmpf_pkg::cmpf_pmode_t i_pmode,
    // Analog cores
    input wire logic [1:0] i_raw_result,
    output logic [1:0] o_cmp_enable,
    output logic [1:0] o_pos_sel,
    output logic [1:0] o_neg_ref_sel,
    // Pins and events
    output logic [1:0] o_result_pin,
    output logic [1:0] o_result_pin_oe,
    output logic o_irq,
    output logic o_wake
);
    import cmpf_pkg::*;

    logic [7:0] cfg_r [2];
    logic [1:0] mask_r;
    logic [7:0] pwr_r;
    cmpf_data_t rdata_r;
    logic [1:0] result_s;
    logic [1:0] flag_s;
    logic [1:0] change_s;
    logic [1:0] clr_s;
    logic [1:0] active_s;
    logic [1:0] pend_s;
    logic tpd_s;
    logic irq_r;
    logic wake_r;
    logic [1:0] en_r;
    logic [1:0] psel_r;
    logic [1:0] nsel_r;
    logic [1:0] pin_r;
    logic [1:0] pin_oe_r;
    logic [1:0] stat_clr_s;

    function automatic logic hit(input cmpf_addr_t a, input cmpf_addr_t ofs);
        hit = (a == ofs);
    endfunction : hit

    assign tpd_s = (i_pmode == CMPF_TPD);

    // Power gating: aux bit or total power-down stops both cores
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            active_s[i] = cfg_r[i][`CMPF_BIT_EN]
                && !pwr_r[`CMPF_BIT_PWROFF] && !tpd_s;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_ch
            assign clr_s[g] = stat_clr_s[g] || (i_wr
                && hit(i_addr, g ? `CMPF_OFS_CFG1 : `CMPF_OFS_CFG0)
                && !i_wdata[`CMPF_BIT_FLAG]);
            cmpf_chan u_chan (
                .i_clk_sys(i_clk_sys),
                .i_sys_rst(i_sys_rst),
                .i_active(active_s[g]),
                .i_clr(clr_s[g]),
                .i_raw(i_raw_result[g]),
                .o_result(result_s[g]),
                .o_flag(flag_s[g]),
                .o_change(change_s[g])
            );
        end
    endgenerate

    // Config registers; flag bit lives in the channel, not here
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            cfg_r[0] <= `CMPF_RST_CFG;
            cfg_r[1] <= `CMPF_RST_CFG;
        end else if (i_wr) begin
            if (hit(i_addr, `CMPF_OFS_CFG0)) begin
                cfg_r[0] <= i_wdata;
            end
            if (hit(i_addr, `CMPF_OFS_CFG1)) begin
                cfg_r[1] <= i_wdata;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            mask_r <= 2'h0;
        end else if (i_wr && hit(i_addr, `CMPF_OFS_MASK)) begin
            mask_r <= i_wdata[1:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            pwr_r <= `CMPF_RST_PWR;
        end else if (i_wr && hit(i_addr, `CMPF_OFS_PWR)) begin
            pwr_r <= i_wdata;
        end
    end

    // Status bit writes one to clear map onto the same flags
    assign stat_clr_s = (i_wr && hit(i_addr, `CMPF_OFS_STAT))
        ? i_wdata[1:0] : 2'h0;

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                `CMPF_OFS_CFG0: rdata_r <= {1'b0, result_s[0], flag_s[0],
                    cfg_r[0][4:0]};
                `CMPF_OFS_CFG1: rdata_r <= {1'b0, result_s[1], flag_s[1],
                    cfg_r[1][4:0]};
                `CMPF_OFS_STAT: rdata_r <= {6'h00, flag_s};
                `CMPF_OFS_MASK: rdata_r <= {6'h00, mask_r};
                `CMPF_OFS_PWR: rdata_r <= pwr_r;
                default: rdata_r <= 8'h00;
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // Pending: flag, its enable and the status mask
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            pend_s[i] = flag_s[i] && cfg_r[i][`CMPF_BIT_IEN] && mask_r[i];
        end
    end

    // One shared line for both comparators
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |pend_s;
        end
    end

    // Wake request in idle and power-down. With the oscillator stopped the
    // core's wake logic must also watch o_cmp_enable and i_raw_result; this
    // registered path covers the slow-clock case.
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= ((i_pmode == CMPF_IDLE) || (i_pmode == CMPF_PD))
                && |(pend_s | (change_s & {cfg_r[1][`CMPF_BIT_IEN],
                cfg_r[0][`CMPF_BIT_IEN]}));
        end
    end

    // Analog controls and pin drive, registered for clean outputs
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            en_r <= 2'h0;
            psel_r <= 2'h0;
            nsel_r <= 2'h0;
            pin_r <= 2'h3;
            pin_oe_r <= 2'h0;
        end else begin
            en_r <= active_s;
            psel_r <= {cfg_r[1][`CMPF_BIT_PSEL], cfg_r[0][`CMPF_BIT_PSEL]};
            nsel_r <= {cfg_r[1][`CMPF_BIT_NSEL],
                cfg_r[0][`CMPF_BIT_NSEL]};
            pin_r <= result_s;
            pin_oe_r <= {cfg_r[1][`CMPF_BIT_OUTEN],
                cfg_r[0][`CMPF_BIT_OUTEN]};
        end
    end

    assign o_rdata = rdata_r;
    assign o_irq = irq_r;
    assign o_wake = wake_r;
    assign o_cmp_enable = en_r;
    assign o_pos_sel = psel_r;
    assign o_neg_ref_sel = nsel_r;
    assign o_result_pin = pin_r;
    assign o_result_pin_oe = pin_oe_r;

    a_irq_follows: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) (|pend_s) |=> o_irq)
        else $error("irq not raised for pending flag");
    a_irq_quiet: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) !(|pend_s) |=> !o_irq)
        else $error("irq raised with nothing pending");
    a_tpd_off: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) tpd_s |=> o_cmp_enable == 2'h0)
        else $error("comparator on in total power-down");
    a_aux_off: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        pwr_r[`CMPF_BIT_PWROFF] |=> o_cmp_enable == 2'h0)
        else $error("aux power bit did not stop comparators");
    a_wake_idle: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        ((i_pmode == CMPF_IDLE) && (|pend_s)) |=> o_wake)
        else $error("no wake in idle");
    a_wake_pd: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        ((i_pmode == CMPF_PD) && (|pend_s)) |=> o_wake)
        else $error("no wake in power-down");
    a_wake_run: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        ((i_pmode == CMPF_RUN) || tpd_s) |=> !o_wake)
        else $error("wake outside idle or power-down");
    a_low_power_on: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        (cfg_r[0][`CMPF_BIT_EN] && !pwr_r[`CMPF_BIT_PWROFF] && !tpd_s)
        |=> o_cmp_enable[0])
        else $error("enabled comparator stopped");
    a_rd_zero: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) !i_rd |=> o_rdata == 8'h00)
        else $error("read data outside read slot");
    a_rd_stat: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) (i_rd && (i_addr == `CMPF_OFS_STAT))
        |=> o_rdata == {6'h00, $past(flag_s)})
        else $error("status read lost a flag");
    a_stat_clear: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        (i_wr && (i_addr == `CMPF_OFS_STAT) && i_wdata[0] && !change_s[0])
        |=> !flag_s[0])
        else $error("status write did not clear flag");
    a_cfg_clear: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        (i_wr && (i_addr == `CMPF_OFS_CFG1)
        && !i_wdata[`CMPF_BIT_FLAG] && !change_s[1]) |=> !flag_s[1])
        else $error("config write did not clear flag");
    a_disable_flag: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        (!active_s[0] && !result_s[0]) |=> flag_s[0])
        else $error("disable from low did not set flag");
    a_disable_second: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst)
        (!active_s[1] && !result_s[1]) |=> flag_s[1])
        else $error("disable from low did not set flag");
    a_pin_follows: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) 1'b1 |=> o_result_pin == $past(result_s))
        else $error("result pin not following result");
    a_neg_sel: assert property (@(posedge i_clk_sys)
        disable iff (i_sys_rst) 1'b1 |=> o_neg_ref_sel == $past(
        {cfg_r[1][`CMPF_BIT_NSEL], cfg_r[0][`CMPF_BIT_NSEL]}))
        else $error("minus select not following config");
endmodule : cmpf_top

// ==== tb/cmpf_analog_model.sv ====
`timescale 1ns/1ns
module cmpf_analog_model #(
    parameter int REF_MV = 1230
) (
    // Control from the digital block
    input wire logic i_en,
    input wire logic i_psel,
    input wire logic i_nref,
    // Pin levels in millivolts
    input wire integer i_pa_mv,
    input wire integer i_pb_mv,
    input wire integer i_n_mv,
    // Raw result
    output logic o_raw
);
    int p;
    int n;
    // Unpowered core shows low, so only the forcing logic can make a one
    always_comb begin
        p = i_psel ? i_pb_mv : i_pa_mv;
        n = i_nref ? REF_MV : i_n_mv;
        o_raw = i_en && (p > n);
    end
endmodule : cmpf_analog_model

// ==== tb/cmpf_top_tb.sv ====
`timescale 1ns/1ns
`include "cmpf_consts.svh"
module cmpf_top_tb;
    import cmpf_pkg::*;
    localparam int REF_MV = 1230;
    logic clk = 1'b0;
    logic rst = 1'b1;
    cmpf_addr_t addr = 8'h00;
    cmpf_data_t wdata = 8'h00;
    logic bwr = 1'b0;
    logic brd = 1'b0;
    cmpf_data_t rdata;
    cmpf_pmode_t pm = CMPF_RUN;
    logic [1:0] raw, en, psel, nref, pin, oe;
    logic irq, wake;
    int pa[2] = '{0, 0};
    int pb[2] = '{0, 0};
    int nn[2] = '{0, 0};
    int fails = 0;
    int checked = 0;
    cmpf_data_t d;
    always #25 clk = ~clk;
    cmpf_top u_cmpf_top (.i_clk_sys(clk), .i_sys_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(bwr), .i_rd(brd), .o_rdata(rdata),
        .i_pmode(pm), .i_raw_result(raw), .o_cmp_enable(en),
        .o_pos_sel(psel), .o_neg_ref_sel(nref), .o_result_pin(pin),
        .o_result_pin_oe(oe), .o_irq(irq), .o_wake(wake));
    for (genvar g = 0; g < 2; g++) begin : g_ana
        cmpf_analog_model #(.REF_MV(REF_MV)) u_cmpf_analog_model (
            .i_en(en[g]), .i_psel(psel[g]), .i_nref(nref[g]),
            .i_pa_mv(pa[g]), .i_pb_mv(pb[g]), .i_n_mv(nn[g]),
            .o_raw(raw[g]));
    end
    task automatic conclude();
        if (fails == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic reg_wr(cmpf_addr_t a, cmpf_data_t v);
        @(posedge clk);
        bwr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        bwr <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(cmpf_addr_t a);
        @(posedge clk);
        brd <= 1'b1;
        addr <= a;
        @(posedge clk);
        brd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    task automatic wt(int n);
        repeat (n) @(negedge clk);
    endtask : wt
    function automatic cmpf_addr_t cfg(int c);
        return c ? `CMPF_OFS_CFG1 : `CMPF_OFS_CFG0;
    endfunction : cfg
    function automatic logic exp_res(int c, logic ps, logic nr);
        return (ps ? pb[c] : pa[c]) > (nr ? REF_MV : nn[c]);
    endfunction : exp_res
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end
    initial begin
        int sd;
        int c;
        logic ps;
        logic nr;
        sd = $urandom(84088);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wt(4);
        chk("pins", {6'h0, pin}, 8'h03);
        chk("oe", {6'h0, oe}, 8'h00);
        reg_rd(cfg(0));
        chk("cfg0 res", d & 8'h40, 8'h40);
        reg_rd(8'h14);
        chk("unmapped", d, 8'h00);
        reg_rd(`CMPF_OFS_MASK);
        chk("mask", d, `CMPF_RST_MASK);
        repeat (8) begin
            c = $urandom_range(1, 0);
            ps = 1'($urandom);
            nr = 1'($urandom);
            pa[c] = $urandom_range(2500, 0);
            pb[c] = $urandom_range(2500, 0);
            nn[c] = $urandom_range(2500, 0);
            reg_wr(cfg(c), {2'b00, 1'b1, 1'b0, nr, ps, 2'b11});
            wt(6);
            chk("sel", {6'h0, psel[c], nref[c]}, {6'h0, ps, nr});
            chk("pin", {7'h0, pin[c]}, {7'h0, exp_res(c, ps, nr)});
            chk("oe", {7'h0, oe[c]}, 8'h01);
            reg_rd(cfg(c));
            chk("res", d & 8'h40, {1'b0, exp_res(c, ps, nr), 6'h0});
        end
        pa[0] = 2000;
        nn[0] = 1000;
        reg_wr(cfg(0), 8'h23);
        wt(`CMPF_SETTLE_CYC);
        reg_wr(`CMPF_OFS_STAT, 8'h03);
        reg_wr(`CMPF_OFS_MASK, 8'h03);
        reg_wr(cfg(0), 8'h13);
        wt(2);
        chk("irq quiet", {7'h0, irq}, 8'h00);
        pa[0] = 1000;
        wt(6);
        chk("irq fall", {7'h0, irq}, 8'h01);
        reg_rd(`CMPF_OFS_STAT);
        chk("stat", d & 8'h03, 8'h01);
        pa[0] = 2000;
        wt(6);
        reg_rd(cfg(0));
        chk("cfg0 rise", d & 8'h60, 8'h60);
        reg_wr(cfg(0), 8'h13);
        wt(2);
        chk("irq clr", {7'h0, irq}, 8'h00);
        reg_wr(`CMPF_OFS_MASK, 8'h00);
        pa[0] = 500;
        wt(6);
        chk("irq masked", {7'h0, irq}, 8'h00);
        reg_wr(`CMPF_OFS_MASK, 8'h01);
        wt(2);
        chk("irq unmask", {7'h0, irq}, 8'h01);
        reg_wr(`CMPF_OFS_STAT, 8'h01);
        wt(2);
        chk("irq stat", {7'h0, irq}, 8'h00);
        @(posedge clk);
        pm <= CMPF_IDLE;
        pa[0] = 2000;
        wt(6);
        chk("wake", {7'h0, wake}, 8'h01);
        chk("irq idle", {7'h0, irq}, 8'h01);
        @(posedge clk);
        pm <= CMPF_RUN;
        pa[0] = 500;
        wt(6);
        chk("wake run", {7'h0, wake}, 8'h00);
        reg_wr(cfg(0), 8'h23);
        reg_wr(`CMPF_OFS_STAT, 8'h01);
        reg_wr(cfg(0), 8'h20);
        wt(3);
        chk("irq off", {7'h0, irq}, 8'h00);
        reg_rd(cfg(0));
        chk("cfg0 off", d & 8'h60, 8'h60);
        reg_wr(`CMPF_OFS_STAT, 8'h01);
        reg_rd(cfg(0));
        chk("cfg0 clr", d & 8'h60, 8'h40);
        pa[1] = 500;
        nn[1] = 1000;
        reg_wr(cfg(1), 8'h21);
        wt(`CMPF_SETTLE_CYC);
        reg_wr(`CMPF_OFS_STAT, 8'h03);
        reg_wr(cfg(1), 8'h31);
        reg_wr(`CMPF_OFS_MASK, 8'h02);
        reg_wr(`CMPF_OFS_PWR, 8'h20);
        wt(4);
        chk("en pwr", {6'h0, en}, 8'h00);
        chk("irq pwr", {7'h0, irq}, 8'h01);
        reg_rd(cfg(1));
        chk("cfg1 off", d & 8'h40, 8'h40);
        reg_rd(`CMPF_OFS_PWR);
        chk("pwr", d, 8'h20);
        reg_wr(`CMPF_OFS_PWR, 8'h00);
        wt(4);
        chk("en back", {6'h0, en}, 8'h02);
        @(posedge clk);
        pm <= CMPF_TPD;
        wt(3);
        chk("en tpd", {6'h0, en}, 8'h00);
        @(posedge clk);
        pm <= CMPF_RUN;
        conclude();
    end
endmodule : cmpf_top_tb
